/* core/spd_decode.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - A mandatory prefix of F2H, F3H or 66H, then 0FH, then an opcode byte forms the three-byte form, and that prefix selects the instruction.
// RULE_02 - With a memory operand, the 67H prefix flips the effective address size used for that operand.
// RULE_03 - With a memory operand, any of the six segment override bytes selects the segment for the access.
// RULE_04 - On register-only forms, address-size and segment overrides are reserved and handled in a fixed implementation way.
// RULE_05 - Repeat prefixes that are not the mandatory prefix are reserved and handled in a fixed implementation way.
// RULE_06 - A lock prefix on any instruction of the group raises the invalid opcode fault instead of execution.
// RULE_07 - Branch hint prefixes E2H and E3H are reserved and handled in a fixed implementation way.
// RULE_08 - Every reserved case has one fixed outcome, ignore or fault, applied identically every time.
module spd_decode (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 fetch_valid,
	input  wire logic [7:0]           fetch_byte,
	input  wire logic                 mode_addr32,
	output logic                      dec_valid,
	output logic [7:0]                dec_opcode,
	output spd_pkg::spd_mand_e        dec_mand,
	output logic                      dec_mem,
	output logic                      dec_addr32,
	output spd_pkg::spd_seg_t         dec_seg,
	output logic                      dec_seg_ovr,
	output logic                      invalid_opcode_fault,
	output logic                      dec_other
);
	import spd_pkg::*;

	spd_cls_if cls ();

	// byte classifier
	spd_prefix_class u_class (
		.c (cls.cls)
	);

	assign cls.byte_in = fetch_byte;

	// mandatory prefix: last repeat byte wins, else operand size
	function automatic spd_mand_e mand_of(input spd_pfx_s p);
		if (p.f2 || p.f3)
			mand_of = p.last_f3 ? MAND_F3 : MAND_F2;
		else if (p.opsz)
			mand_of = MAND_OPSZ;
		else
			mand_of = MAND_NONE;
	endfunction

	// fault decision, fixed per reserved case
	function automatic logic fault_of(input spd_pfx_s p, input logic mem);
		fault_of = p.lock
			|| (POL_REP_FAULT && p.f2 && p.f3)
			|| (POL_HINT_FAULT && p.hint)
			|| (POL_ADDR_FAULT && p.addr && !mem)
			|| (POL_SEG_FAULT && p.seg_ovr && !mem);
	endfunction

	spd_state_e state_r;
	spd_state_e state_nxt;
	spd_pfx_s   pfx_r;
	spd_pfx_s   pfx_nxt;
	logic [7:0] opc_r;
	logic [7:0] opc_nxt;
	logic       mem_w;
	logic       dec_valid_r;
	logic       dec_valid_nxt;
	logic [7:0] dec_opcode_r;
	logic [7:0] dec_opcode_nxt;
	spd_mand_e  dec_mand_r;
	spd_mand_e  dec_mand_nxt;
	logic       dec_mem_r;
	logic       dec_mem_nxt;
	logic       dec_addr32_r;
	logic       dec_addr32_nxt;
	spd_seg_t   dec_seg_r;
	spd_seg_t   dec_seg_nxt;
	logic       dec_seg_ovr_r;
	logic       dec_seg_ovr_nxt;
	logic       fault_r;
	logic       fault_nxt;
	logic       other_r;
	logic       other_nxt;

	assign mem_w = (fetch_byte[7:6] != MOD_REG);

	// sequence and prefix gathering, next values
	always_comb begin
		state_nxt = state_r;
		pfx_nxt   = pfx_r;
		opc_nxt   = opc_r;
		other_nxt = 1'b0;
		case (state_r)
			ST_PFX: begin
				if (fetch_valid) begin
					if (cls.is_esc) begin
						state_nxt = ST_OPC; // RULE_01
					end else if (cls.is_prefix) begin
						if (cls.is_opsz)
							pfx_nxt.opsz = 1'b1;
						if (cls.is_f2) begin
							pfx_nxt.f2      = 1'b1;
							pfx_nxt.last_f3 = 1'b0;
						end
						if (cls.is_f3) begin
							pfx_nxt.f3      = 1'b1;
							pfx_nxt.last_f3 = 1'b1;
						end
						if (cls.is_lock)
							pfx_nxt.lock = 1'b1;
						if (cls.is_addr)
							pfx_nxt.addr = 1'b1;
						if (cls.is_seg) begin
							pfx_nxt.seg_ovr = 1'b1;
							pfx_nxt.seg     = cls.seg_code; // last wins
						end
						if (cls.is_hint)
							pfx_nxt.hint = 1'b1;
					end else begin
						other_nxt = 1'b1; // not this group
						pfx_nxt   = '0;
					end
				end
			end
			ST_OPC: begin
				if (fetch_valid) begin
					opc_nxt   = fetch_byte;
					state_nxt = ST_MODRM;
				end
			end
			ST_MODRM: begin
				if (fetch_valid) begin
					pfx_nxt   = '0;
					state_nxt = ST_PFX;
				end
			end
			default: begin
				pfx_nxt   = '0;
				state_nxt = ST_PFX;
			end
		endcase
	end

	// sequence registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_PFX;
			pfx_r   <= '0;
			opc_r   <= 8'h00;
			other_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pfx_r   <= pfx_nxt;
			opc_r   <= opc_nxt;
			other_r <= other_nxt;
		end
	end

	// decoded result, next values; fields hold between pulses
	always_comb begin
		dec_valid_nxt   = 1'b0;
		fault_nxt       = 1'b0;
		dec_opcode_nxt  = dec_opcode_r;
		dec_mand_nxt    = dec_mand_r;
		dec_mem_nxt     = dec_mem_r;
		dec_addr32_nxt  = dec_addr32_r;
		dec_seg_nxt     = dec_seg_r;
		dec_seg_ovr_nxt = dec_seg_ovr_r;
		if (state_r == ST_MODRM && fetch_valid) begin
			dec_valid_nxt   = 1'b1;
			dec_opcode_nxt  = opc_r;
			dec_mand_nxt    = mand_of(pfx_r); // RULE_01 RULE_05
			dec_mem_nxt     = mem_w;
			dec_addr32_nxt  = mode_addr32 ^ (mem_w && pfx_r.addr); // RULE_02 RULE_04
			dec_seg_ovr_nxt = mem_w && pfx_r.seg_ovr; // RULE_03 RULE_04
			dec_seg_nxt     = (mem_w && pfx_r.seg_ovr) ? pfx_r.seg : SREG_DS;
			fault_nxt       = fault_of(pfx_r, mem_w); // RULE_06 RULE_07 RULE_08
		end
	end

	// decoded result registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dec_valid_r   <= 1'b0;
			dec_opcode_r  <= 8'h00;
			dec_mand_r    <= MAND_NONE;
			dec_mem_r     <= 1'b0;
			dec_addr32_r  <= 1'b0;
			dec_seg_r     <= SREG_DS;
			dec_seg_ovr_r <= 1'b0;
			fault_r       <= 1'b0;
		end else begin
			dec_valid_r   <= dec_valid_nxt;
			dec_opcode_r  <= dec_opcode_nxt;
			dec_mand_r    <= dec_mand_nxt;
			dec_mem_r     <= dec_mem_nxt;
			dec_addr32_r  <= dec_addr32_nxt;
			dec_seg_r     <= dec_seg_nxt;
			dec_seg_ovr_r <= dec_seg_ovr_nxt;
			fault_r       <= fault_nxt;
		end
	end

	// outputs straight from flops
	assign dec_valid            = dec_valid_r;
	assign dec_opcode           = dec_opcode_r;
	assign dec_mand             = dec_mand_r;
	assign dec_mem              = dec_mem_r;
	assign dec_addr32           = dec_addr32_r;
	assign dec_seg              = dec_seg_r;
	assign dec_seg_ovr          = dec_seg_ovr_r;
	assign invalid_opcode_fault = fault_r;
	assign dec_other            = other_r;

	// checks on the decode sequence
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_escape_entry: assert property ( // RULE_01
		state_r == ST_OPC && $past(state_r) == ST_PFX
		|-> $past(fetch_valid) && $past(fetch_byte) == PFX_ESC)
		else $error("opcode state entered without escape byte");

	a_mand_select: assert property ( // RULE_01
		state_r == ST_MODRM && fetch_valid && pfx_r.f3 && pfx_r.last_f3
		|=> dec_valid && dec_mand == MAND_F3)
		else $error("f3 mandatory prefix not selected");

	a_addr_mem: assert property ( // RULE_02
		state_r == ST_MODRM && fetch_valid && mem_w
		|=> dec_addr32 == ($past(mode_addr32) ^ $past(pfx_r.addr)))
		else $error("address size override not applied");

	a_seg_mem: assert property ( // RULE_03
		state_r == ST_MODRM && fetch_valid && mem_w && pfx_r.seg_ovr
		|=> dec_seg_ovr && dec_seg == $past(pfx_r.seg))
		else $error("segment override not applied");

	a_reg_only: assert property ( // RULE_04
		dec_valid && !dec_mem
		|-> !dec_seg_ovr && dec_seg == SREG_DS
			&& dec_addr32 == $past(mode_addr32))
		else $error("override acted on register-only form");

	a_rep_extra: assert property ( // RULE_05
		state_r == ST_MODRM && fetch_valid && pfx_r.f2 && pfx_r.f3
			&& !pfx_r.lock && !pfx_r.hint
		|=> invalid_opcode_fault == POL_REP_FAULT)
		else $error("extra repeat prefix handled wrongly");

	a_lock_fault: assert property ( // RULE_06
		state_r == ST_MODRM && fetch_valid && pfx_r.lock
		|=> dec_valid && invalid_opcode_fault)
		else $error("lock prefix did not fault");

	a_hint_fixed: assert property ( // RULE_07
		state_r == ST_MODRM && fetch_valid && pfx_r.hint
			&& !pfx_r.lock && !(pfx_r.f2 && pfx_r.f3)
		|=> invalid_opcode_fault == POL_HINT_FAULT)
		else $error("branch hint handled wrongly");

	a_fault_fixed: assert property ( // RULE_08
		invalid_opcode_fault |-> dec_valid
			&& $past(state_r) == ST_MODRM && $past(fetch_valid))
		else $error("fault outside a decode pulse");

endmodule // spd_decode

/* core/spd_prefix_class.sv */
`timescale 1ns/1ps
module spd_prefix_class (
	spd_cls_if.cls c
);
	import spd_pkg::*;

	// map a segment override byte to its register code
	function automatic spd_seg_t seg_of(input logic [7:0] b);
		case (b)
			PFX_SEG_CS: seg_of = SREG_CS;
			PFX_SEG_SS: seg_of = SREG_SS;
			PFX_SEG_DS: seg_of = SREG_DS;
			PFX_SEG_ES: seg_of = SREG_ES;
			PFX_SEG_FS: seg_of = SREG_FS;
			PFX_SEG_GS: seg_of = SREG_GS;
			default:    seg_of = SREG_DS;
		endcase
	endfunction

	// byte class decode
	always_comb begin
		c.is_esc   = (c.byte_in == PFX_ESC);
		c.is_opsz  = (c.byte_in == PFX_OPSZ);
		c.is_f2    = (c.byte_in == PFX_REPNE);
		c.is_f3    = (c.byte_in == PFX_REPE);
		c.is_lock  = (c.byte_in == PFX_LOCK);
		c.is_addr  = (c.byte_in == PFX_ADDR);
		c.is_hint  = (c.byte_in == PFX_HINT_A) || (c.byte_in == PFX_HINT_B);
		c.is_seg   = (c.byte_in == PFX_SEG_CS) || (c.byte_in == PFX_SEG_SS)
			|| (c.byte_in == PFX_SEG_DS) || (c.byte_in == PFX_SEG_ES)
			|| (c.byte_in == PFX_SEG_FS) || (c.byte_in == PFX_SEG_GS);
		c.seg_code = seg_of(c.byte_in);
		c.is_prefix = c.is_opsz || c.is_f2 || c.is_f3 || c.is_lock
			|| c.is_addr || c.is_hint || c.is_seg;
	end

endmodule // spd_prefix_class

/* pkg/spd_cls_if.sv */
`timescale 1ns/1ps
interface spd_cls_if;
	import spd_pkg::*;
	logic [7:0] byte_in;
	logic       is_prefix;
	logic       is_esc;
	logic       is_opsz;
	logic       is_f2;
	logic       is_f3;
	logic       is_lock;
	logic       is_addr;
	logic       is_seg;
	logic       is_hint;
	spd_seg_t   seg_code;

	modport cls (
		input  byte_in,
		output is_prefix, is_esc, is_opsz, is_f2, is_f3, is_lock,
		output is_addr, is_seg, is_hint, seg_code
	);
	modport use_cls (
		output byte_in,
		input  is_prefix, is_esc, is_opsz, is_f2, is_f3, is_lock,
		input  is_addr, is_seg, is_hint, seg_code
	);
endinterface

/* pkg/spd_pkg.sv */
package spd_pkg;

	// prefix and escape byte values
	localparam logic [7:0] PFX_OPSZ   = 8'h66;
	localparam logic [7:0] PFX_REPNE  = 8'hf2;
	localparam logic [7:0] PFX_REPE   = 8'hf3;
	localparam logic [7:0] PFX_ESC    = 8'h0f;
	localparam logic [7:0] PFX_ADDR   = 8'h67;
	localparam logic [7:0] PFX_LOCK   = 8'hf0;
	localparam logic [7:0] PFX_HINT_A = 8'he2;
	localparam logic [7:0] PFX_HINT_B = 8'he3;
	localparam logic [7:0] PFX_SEG_CS = 8'h2e;
	localparam logic [7:0] PFX_SEG_SS = 8'h36;
	localparam logic [7:0] PFX_SEG_DS = 8'h3e;
	localparam logic [7:0] PFX_SEG_ES = 8'h26;
	localparam logic [7:0] PFX_SEG_FS = 8'h64;
	localparam logic [7:0] PFX_SEG_GS = 8'h65;

	// segment register codes
	typedef logic [2:0] spd_seg_t;
	localparam spd_seg_t SREG_ES = 3'h0;
	localparam spd_seg_t SREG_CS = 3'h1;
	localparam spd_seg_t SREG_SS = 3'h2;
	localparam spd_seg_t SREG_DS = 3'h3;
	localparam spd_seg_t SREG_FS = 3'h4;
	localparam spd_seg_t SREG_GS = 3'h5;

	// modrm mod field that means register-only operands
	localparam logic [1:0] MOD_REG = 2'h3;

	// fixed handling of reserved prefixes: 1 faults, 0 ignores
	localparam logic POL_REP_FAULT  = 1'b0;
	localparam logic POL_HINT_FAULT = 1'b0;
	localparam logic POL_ADDR_FAULT = 1'b0;
	localparam logic POL_SEG_FAULT  = 1'b0;

	// mandatory prefix selection
	typedef enum logic [1:0] {
		MAND_NONE = 2'b00,
		MAND_OPSZ = 2'b01,
		MAND_F2   = 2'b10,
		MAND_F3   = 2'b11
	} spd_mand_e;

	// decoder sequence states
	typedef enum logic [1:0] {
		ST_PFX   = 2'b00,
		ST_OPC   = 2'b01,
		ST_MODRM = 2'b10
	} spd_state_e;

	// prefixes gathered ahead of the escape byte
	typedef struct packed {
		logic     opsz;
		logic     f2;
		logic     f3;
		logic     last_f3;
		logic     lock;
		logic     addr;
		logic     seg_ovr;
		spd_seg_t seg;
		logic     hint;
	} spd_pfx_s;

endpackage

/* verification/simd_prefix_decode_bench.sv */
`timescale 1ns/1ps
module simd_prefix_decode_bench;
	import spd_pkg::*;
	logic       clk;
	logic       rst_n = 1'b0;
	logic       mode_addr32 = 1'b1;
	logic       gap_en = 1'b0;
	logic       fetch_valid;
	logic [7:0] fetch_byte;
	logic       dec_valid;
	logic [7:0] dec_opcode;
	spd_mand_e  dec_mand;
	logic       dec_mem;
	logic       dec_addr32;
	spd_seg_t   dec_seg;
	logic       dec_seg_ovr;
	logic       invalid_opcode_fault;
	logic       dec_other;
	logic       last_flt = 1'b0;
	int         fails = 0;
	int         cmp_count = 0;
	int         n_valid = 0;
	int         n_fault = 0;
	int         n_other = 0;

	spd_decode u_spd_decode (.clk(clk), .rst_n(rst_n),
		.fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
		.mode_addr32(mode_addr32), .dec_valid(dec_valid),
		.dec_opcode(dec_opcode), .dec_mand(dec_mand), .dec_mem(dec_mem),
		.dec_addr32(dec_addr32), .dec_seg(dec_seg),
		.dec_seg_ovr(dec_seg_ovr),
		.invalid_opcode_fault(invalid_opcode_fault),
		.dec_other(dec_other));
	spd_fetch_model u_spd_fetch_model (.clk(clk), .gap_en(gap_en),
		.fetch_valid(fetch_valid), .fetch_byte(fetch_byte));

	// 200 mhz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task check(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h",
				$time, what, seen, exp);
		end
	endtask

	// count result pulses, faults and dropped-prefix pulses
	always @(posedge clk) begin
		if (dec_valid === 1'b1) begin
			n_valid++;
			last_flt = invalid_opcode_fault;
		end
		if (invalid_opcode_fault === 1'b1) begin
			n_fault++;
			check(dec_valid, 1'b1, "fault without result");
		end
		if (dec_other === 1'b1)
			n_other++;
	end

	// feed bytes and wait for nv results
	task run(input logic [7:0] b[$], input int nv);
		int start;
		int k;
		start = n_valid;
		k = 0;
		foreach (b[i])
			u_spd_fetch_model.push(b[i]);
		while (n_valid < start + nv && k < 200) begin
			@(posedge clk);
			k++;
		end
		check(k < 200, 1'b1, "result pulse missing");
		#1;
	endtask

	task expect_out(input logic [7:0] op, input spd_mand_e m,
		input logic mem, input logic a32, input spd_seg_t sg,
		input logic ovr, input logic flt);
		check(dec_opcode, op, "opcode");
		check(dec_mand, m, "mandatory prefix");
		check(dec_mem, mem, "memory form");
		check(dec_addr32, a32, "address size");
		check(dec_seg, sg, "segment");
		check(dec_seg_ovr, ovr, "segment override");
		check(last_flt, flt, "fault");
	endtask

	task t_mand;
		logic [7:0] pfx [4];
		spd_mand_e  mnd [4];
		pfx = '{PFX_REPE, PFX_REPNE, PFX_OPSZ, PFX_ESC};
		mnd = '{MAND_F3, MAND_F2, MAND_OPSZ, MAND_NONE};
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				run('{PFX_ESC, 8'h5b, 8'h04}, 1);
			else
				run('{pfx[i], PFX_ESC, 8'h58 + i[7:0], 8'h04}, 1);
			expect_out(8'h58 + i[7:0], mnd[i], 1, 1, SREG_DS, 0, 0);
		end
	endtask

	task t_addr;
		for (int m = 0; m < 2; m++) begin
			mode_addr32 = m[0];
			run('{PFX_ADDR, PFX_OPSZ, PFX_ESC, 8'h54, 8'h04}, 1);
			expect_out(8'h54, MAND_OPSZ, 1, ~m[0], SREG_DS, 0, 0);
			run('{PFX_ADDR, PFX_OPSZ, PFX_ESC, 8'h55, 8'hc0}, 1);
			expect_out(8'h55, MAND_OPSZ, 0, m[0], SREG_DS, 0, 0);
		end
		mode_addr32 = 1'b1;
	endtask

	task t_seg;
		logic [7:0] pb [6];
		spd_seg_t   sc [6];
		pb = '{PFX_SEG_CS, PFX_SEG_SS, PFX_SEG_DS, PFX_SEG_ES, PFX_SEG_FS,
			PFX_SEG_GS};
		sc = '{SREG_CS, SREG_SS, SREG_DS, SREG_ES, SREG_FS, SREG_GS};
		for (int i = 0; i < 6; i++) begin
			run('{pb[i], PFX_REPNE, PFX_ESC, 8'h51, 8'h44}, 1);
			expect_out(8'h51, MAND_F2, 1, 1, sc[i], 1, 0);
		end
		run('{PFX_SEG_CS, PFX_SEG_GS, PFX_REPNE, PFX_ESC, 8'h50, 8'h04}, 1);
		expect_out(8'h50, MAND_F2, 1, 1, SREG_GS, 1, 0);
		run('{PFX_SEG_FS, PFX_REPNE, PFX_ESC, 8'h52, 8'hc1}, 1);
		expect_out(8'h52, MAND_F2, 0, 1, SREG_DS, 0, 0);
	endtask

	// reserved prefixes, run twice to see the same outcome
	task t_resv;
		for (int r = 0; r < 2; r++) begin
			run('{PFX_REPNE, PFX_REPE, PFX_ESC, 8'h10, 8'h04}, 1);
			expect_out(8'h10, MAND_F3, 1, 1, SREG_DS, 0, 0);
			run('{PFX_REPE, PFX_OPSZ, PFX_REPNE, PFX_ESC, 8'h11, 8'h04}, 1);
			expect_out(8'h11, MAND_F2, 1, 1, SREG_DS, 0, 0);
			run('{PFX_HINT_A, PFX_OPSZ, PFX_ESC, 8'h12, 8'hc2}, 1);
			expect_out(8'h12, MAND_OPSZ, 0, 1, SREG_DS, 0, 0);
			run('{PFX_HINT_B, PFX_REPE, PFX_ESC, 8'h13, 8'h04}, 1);
			expect_out(8'h13, MAND_F3, 1, 1, SREG_DS, 0, 0);
		end
	endtask

	// lock then a clean instruction back to back, with fetch gaps
	task t_lock;
		int f;
		gap_en = 1'b1;
		f = n_fault;
		run('{PFX_LOCK, PFX_REPE, PFX_ESC, 8'h58, 8'hc0,
			PFX_OPSZ, PFX_ESC, 8'h59, 8'h04}, 2);
		check(8'(n_fault - f), 8'h01, "fault count");
		expect_out(8'h59, MAND_OPSZ, 1, 1, SREG_DS, 0, 0);
		run('{PFX_OPSZ, PFX_LOCK, PFX_ESC, 8'h5a, 8'h04}, 1);
		expect_out(8'h5a, MAND_OPSZ, 1, 1, SREG_DS, 0, 1);
		gap_en = 1'b0;
	endtask

	// a stray byte drops the gathered lock prefix
	task t_other;
		int o;
		o = n_other;
		run('{PFX_LOCK, 8'h90, PFX_OPSZ, PFX_ESC, 8'h5b, 8'h04}, 1);
		check(8'(n_other - o), 8'h01, "dropped prefix pulse");
		expect_out(8'h5b, MAND_OPSZ, 1, 1, SREG_DS, 0, 0);
	endtask

	// reset in mid-instruction drops gathered prefixes and state
	task t_reset;
		u_spd_fetch_model.push(PFX_LOCK);
		u_spd_fetch_model.push(PFX_ESC);
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check(dec_valid, 1'b0, "reset result pulse");
		check(invalid_opcode_fault, 1'b0, "reset fault");
		check(dec_other, 1'b0, "reset dropped pulse");
		expect_out(8'h00, MAND_NONE, 0, 0, SREG_DS, 0, 0);
		run('{PFX_OPSZ, PFX_ESC, 8'h5c, 8'h04}, 1);
		expect_out(8'h5c, MAND_OPSZ, 1, 1, SREG_DS, 0, 0);
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard, well beyond the expected run length
	initial begin
		#50000;
		fails++;
		complete_run();
	end

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check(dec_valid, 1'b0, "reset result pulse");
		check(dec_seg, SREG_DS, "reset segment");
		t_mand();
		t_addr();
		t_seg();
		t_resv();
		t_lock();
		t_other();
		t_reset();
		complete_run();
	end
endmodule // simd_prefix_decode_bench

/* verification/spd_fetch_model.sv */
`timescale 1ns/1ps
module spd_fetch_model (
	input  wire logic       clk,
	input  wire logic       gap_en,
	output logic            fetch_valid,
	output logic [7:0]      fetch_byte
);
	logic [7:0] q [$];
	logic [7:0] last_r;
	logic       skip_r;

	// idle bus at time zero
	initial begin
		fetch_valid = 1'b0;
		fetch_byte  = 8'h00;
		last_r      = 8'h00;
		skip_r      = 1'b0;
	end

	// one byte per cycle, every other cycle when gaps are on
	always @(posedge clk) begin
		#1;
		if (q.size() != 0 && !(gap_en && skip_r)) begin
			last_r = q.pop_front();
			fetch_valid = 1'b1;
			fetch_byte = last_r;
		end else begin
			fetch_valid = 1'b0;
			fetch_byte = ~last_r; // no stale byte between transfers
		end
		skip_r = ~skip_r;
	end

	// queue a byte for fetch
	task push(input logic [7:0] b);
		q.push_back(b);
	endtask
endmodule // spd_fetch_model
